// file: core/isv_defines.vh
// register offsets, field positions and reset values of the interrupt vectoring block
`ifndef ISV_DEFINES_VH
`define ISV_DEFINES_VH
`define ISV_OFS_BASE_EN 8'h00
`define ISV_OFS_GROUP_EN 8'h04
`define ISV_OFS_TMR_CTRL 8'h08
`define ISV_OFS_TMR2_CTRL 8'h0c
`define ISV_OFS_SER1_CTRL 8'h10
`define ISV_OFS_GROUP_FLAG 8'h14
`define ISV_OFS_G8_EN 8'h18
`define ISV_OFS_G8_FLAG 8'h1c
`define ISV_OFS_G9_EN 8'h20
`define ISV_OFS_G9_FLAG 8'h24
`define ISV_OFS_G10_EN 8'h28
`define ISV_OFS_G10_FLAG 8'h2c
`define ISV_OFS_TIER 8'h30
`define ISV_OFS_STATUS 8'h34
`define ISV_OFS_ENH_EN 8'h38
`define ISV_BIT_GLOBAL_EN 7
`define ISV_BIT_EX0 0
`define ISV_BIT_ET0 1
`define ISV_BIT_EX1 2
`define ISV_BIT_ET1 3
`define ISV_BIT_ET2 5
`define ISV_BIT_ES1 6
`define ISV_BIT_IT0 0
`define ISV_BIT_IE0 1
`define ISV_BIT_IT1 2
`define ISV_BIT_IE1 3
`define ISV_BIT_TMR0_FLAG 5
`define ISV_BIT_TMR1_FLAG 7
`define ISV_BIT_TMR2_OVF 7
`define ISV_BIT_TMR2_EXT 6
`define ISV_BIT_SER1_RX 0
`define ISV_BIT_SER1_TX 1
`define ISV_BIT_G8 4
`define ISV_BIT_G9 5
`define ISV_BIT_G10 6
`define ISV_BIT_ENH_RX 0
`define ISV_BIT_ENH_TX 1
`define ISV_BIT_GRP8_EN 0
`define ISV_BIT_GRP9_EN 1
`define ISV_BIT_GRP10_EN 2
`define ISV_G8_MASK 8'hbf
`define ISV_G9_MASK 8'hec
`define ISV_G10_MASK 8'h07
`define ISV_RST_BYTE 8'h00
`define ISV_RST_TIER 9'h000
`define ISV_VEC_EXT0 8'h03
`define ISV_VEC_T0 8'h0b
`define ISV_VEC_EXT1 8'h13
`define ISV_VEC_T1 8'h1b
`define ISV_VEC_T2 8'h2b
`define ISV_VEC_S1 8'h3b
`define ISV_VEC_G8 8'h43
`define ISV_VEC_G9 8'h4b
`define ISV_VEC_G10 8'h53
`endif

// file: core/isv_pin_sync.v
// two-flop synchroniser and falling-edge detector for the external inputs
`timescale 1ns/1ps
`default_nettype none
module isv_pin_sync #(
    parameter WIDTH = 3
) (
    input wire hclk,
    input wire hresetn,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_sync,
    output reg [WIDTH-1:0] fall_pulse
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] prev_reg;

    // pins idle high, so reset to ones to avoid a false edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= {WIDTH{1'b1}};
            level_sync <= {WIDTH{1'b1}};
            prev_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg <= pin_in;
            level_sync <= meta_reg;
            prev_reg <= level_sync;
        end
    end

    always @* begin
        fall_pulse = prev_reg & ~level_sync;
    end
endmodule // isv_pin_sync
`default_nettype wire

// file: core/isv_irq_vectoring.v
// interrupt source mapping, flags, tiered selection and vector output
`timescale 1ns/1ps
`default_nettype none
`include "isv_defines.vh"
module isv_irq_vectoring #(
    parameter NSRC = 9
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire ext_input_zero,
    input wire ext_input_one,
    input wire ext_input_two,
    input wire timer_zero_ovf,
    input wire timer_one_ovf,
    input wire timer_two_ovf,
    input wire timer_two_ext,
    input wire serial_one_rx,
    input wire serial_one_tx,
    input wire serial_two_tx,
    input wire serial_two_rx,
    input wire serial_four_tx,
    input wire serial_four_rx,
    input wire serial_two_baud_ovf,
    input wire serial_four_baud_ovf,
    input wire calibration_pulse_output_one,
    input wire serial_five_tx,
    input wire serial_five_rx,
    input wire serial_five_baud_ovf,
    input wire rtc_second_pulse,
    input wire calibration_pulse_output_two,
    input wire rtc_illegal_data,
    input wire enh_serial_rx_flag,
    input wire enh_serial_tx_flag,
    input wire enh_serial_overflow_flag,
    output reg irq_request,
    output reg irq_tier,
    output reg [7:0] irq_vector,
    output reg [3:0] irq_number
);
    reg [7:0] base_irq_enable_reg;
    reg [7:0] group_irq_enable_reg;
    reg [7:0] timer_control_reg;
    reg [7:0] timer_two_control_reg;
    reg [7:0] serial_one_control_reg;
    reg [7:0] group_irq_flag_reg;
    reg [7:0] group8_event_enable_reg;
    reg [7:0] group8_event_flag_reg;
    reg [7:0] group9_event_enable_reg;
    reg [7:0] group9_event_flag_reg;
    reg [7:0] group10_event_enable_reg;
    reg [7:0] group10_event_flag_reg;
    reg [7:0] enh_enable_reg;
    reg [NSRC-1:0] tier_reg;
    reg [7:0] addr_reg;
    reg wr_reg;
    reg rd_wait_reg;
    reg [31:0] rdata_next;
    wire [2:0] pin_level;
    wire [2:0] pin_fall;
    wire accept;
    wire [7:0] g8_ev;
    wire [7:0] g9_ev;
    wire [7:0] g10_ev;
    wire enh_ev;
    wire global_irq_enable;
    wire set_ie0;
    wire set_ie1;
    wire g8_req;
    wire g9_req;
    wire g10_req;
    wire [NSRC-1:0] pend;
    wire [NSRC-1:0] pend_hi;
    wire [NSRC-1:0] pend_pick;
    wire [3:0] pick_idx;

    isv_pin_sync #(.WIDTH(3)) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in({ext_input_two, ext_input_one, ext_input_zero}),
        .level_sync(pin_level),
        .fall_pulse(pin_fall)
    );

    // lowest set bit is the smallest polling rank
    function [3:0] first_set;
        input [NSRC-1:0] v;
        integer i;
        begin
            first_set = 4'h0;
            for (i = NSRC - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[3:0];
                end
            end
        end
    endfunction

    function [7:0] vector_of;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: vector_of = `ISV_VEC_EXT0;
                4'h1: vector_of = `ISV_VEC_T0;
                4'h2: vector_of = `ISV_VEC_EXT1;
                4'h3: vector_of = `ISV_VEC_T1;
                4'h4: vector_of = `ISV_VEC_T2;
                4'h5: vector_of = `ISV_VEC_S1;
                4'h6: vector_of = `ISV_VEC_G8;
                4'h7: vector_of = `ISV_VEC_G9;
                default: vector_of = `ISV_VEC_G10;
            endcase
        end
    endfunction

    function [3:0] number_of;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: number_of = 4'h0;
                4'h1: number_of = 4'h1;
                4'h2: number_of = 4'h2;
                4'h3: number_of = 4'h3;
                4'h4: number_of = 4'h5;
                4'h5: number_of = 4'h7;
                4'h6: number_of = 4'h8;
                4'h7: number_of = 4'h9;
                default: number_of = 4'ha;
            endcase
        end
    endfunction

    // set wins over a software write in the same cycle
    function [7:0] flag_upd;
        input [7:0] cur;
        input wr;
        input [7:0] wdata;
        input [7:0] set;
        begin
            flag_upd = (wr ? wdata : cur) | set;
        end
    endfunction

    assign accept = hsel && htrans[1] && hready;
    assign global_irq_enable = base_irq_enable_reg[`ISV_BIT_GLOBAL_EN];

    // mode bit 1 selects falling edge, 0 selects low level
    assign set_ie0 = timer_control_reg[`ISV_BIT_IT0] ? pin_fall[0] : ~pin_level[0];
    assign set_ie1 = timer_control_reg[`ISV_BIT_IT1] ? pin_fall[1] : ~pin_level[1];

    assign g8_ev = {calibration_pulse_output_one, 1'b0, serial_four_baud_ovf,
        serial_two_baud_ovf, serial_four_rx, serial_four_tx, serial_two_rx,
        serial_two_tx};
    assign g9_ev = {calibration_pulse_output_two, rtc_second_pulse, serial_five_baud_ovf,
        1'b0, serial_five_rx, serial_five_tx, 2'b00};
    assign enh_ev = (enh_serial_rx_flag & enh_enable_reg[`ISV_BIT_ENH_RX])
        | (enh_serial_tx_flag & enh_enable_reg[`ISV_BIT_ENH_TX])
        | enh_serial_overflow_flag;
    assign g10_ev = {5'h00, pin_fall[2], enh_ev, rtc_illegal_data};

    // extended request needs group flag and an enabled event flag
    assign g8_req = group_irq_enable_reg[`ISV_BIT_GRP8_EN] & group_irq_flag_reg[`ISV_BIT_G8]
        & |(group8_event_flag_reg & group8_event_enable_reg);
    assign g9_req = group_irq_enable_reg[`ISV_BIT_GRP9_EN] & group_irq_flag_reg[`ISV_BIT_G9]
        & |(group9_event_flag_reg & group9_event_enable_reg);
    assign g10_req = group_irq_enable_reg[`ISV_BIT_GRP10_EN] & group_irq_flag_reg[`ISV_BIT_G10]
        & |(group10_event_flag_reg & group10_event_enable_reg);

    assign pend = {NSRC{global_irq_enable}} & {
        g10_req,
        g9_req,
        g8_req,
        base_irq_enable_reg[`ISV_BIT_ES1] & (serial_one_control_reg[`ISV_BIT_SER1_RX]
            | serial_one_control_reg[`ISV_BIT_SER1_TX]),
        base_irq_enable_reg[`ISV_BIT_ET2] & (timer_two_control_reg[`ISV_BIT_TMR2_OVF]
            | timer_two_control_reg[`ISV_BIT_TMR2_EXT]),
        base_irq_enable_reg[`ISV_BIT_ET1] & timer_control_reg[`ISV_BIT_TMR1_FLAG],
        base_irq_enable_reg[`ISV_BIT_EX1] & timer_control_reg[`ISV_BIT_IE1],
        base_irq_enable_reg[`ISV_BIT_ET0] & timer_control_reg[`ISV_BIT_TMR0_FLAG],
        base_irq_enable_reg[`ISV_BIT_EX0] & timer_control_reg[`ISV_BIT_IE0]};

    assign pend_hi = pend & tier_reg;
    assign pend_pick = (|pend_hi) ? pend_hi : pend;
    assign pick_idx = first_set(pend_pick);

    // ahb-lite slave: writes zero-wait, reads one wait state so a
    // write just before a read is already visible
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 8'h00;
            wr_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_wait_reg) begin
                hrdata <= rdata_next;
                hreadyout <= 1'b1;
                rd_wait_reg <= 1'b0;
                wr_reg <= 1'b0;
            end else if (accept) begin
                addr_reg <= haddr[7:0];
                wr_reg <= hwrite;
                rd_wait_reg <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                wr_reg <= 1'b0;
            end
        end
    end

    always @* begin
        rdata_next = 32'h0000_0000;
        if (addr_reg == `ISV_OFS_BASE_EN) begin
            rdata_next[7:0] = base_irq_enable_reg;
        end else if (addr_reg == `ISV_OFS_GROUP_EN) begin
            rdata_next[7:0] = group_irq_enable_reg;
        end else if (addr_reg == `ISV_OFS_TMR_CTRL) begin
            rdata_next[7:0] = timer_control_reg;
        end else if (addr_reg == `ISV_OFS_TMR2_CTRL) begin
            rdata_next[7:0] = timer_two_control_reg;
        end else if (addr_reg == `ISV_OFS_SER1_CTRL) begin
            rdata_next[7:0] = serial_one_control_reg;
        end else if (addr_reg == `ISV_OFS_GROUP_FLAG) begin
            rdata_next[7:0] = group_irq_flag_reg;
        end else if (addr_reg == `ISV_OFS_G8_EN) begin
            rdata_next[7:0] = group8_event_enable_reg;
        end else if (addr_reg == `ISV_OFS_G8_FLAG) begin
            rdata_next[7:0] = group8_event_flag_reg;
        end else if (addr_reg == `ISV_OFS_G9_EN) begin
            rdata_next[7:0] = group9_event_enable_reg;
        end else if (addr_reg == `ISV_OFS_G9_FLAG) begin
            rdata_next[7:0] = group9_event_flag_reg;
        end else if (addr_reg == `ISV_OFS_G10_EN) begin
            rdata_next[7:0] = group10_event_enable_reg;
        end else if (addr_reg == `ISV_OFS_G10_FLAG) begin
            rdata_next[7:0] = group10_event_flag_reg;
        end else if (addr_reg == `ISV_OFS_TIER) begin
            rdata_next[NSRC-1:0] = tier_reg;
        end else if (addr_reg == `ISV_OFS_STATUS) begin
            rdata_next[13:0] = {irq_request, irq_tier, irq_number, irq_vector};
        end else if (addr_reg == `ISV_OFS_ENH_EN) begin
            rdata_next[7:0] = enh_enable_reg;
        end
    end

    // register file; only implemented bits are stored, the rest read zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_irq_enable_reg <= `ISV_RST_BYTE;
            group_irq_enable_reg <= `ISV_RST_BYTE;
            timer_control_reg <= `ISV_RST_BYTE;
            timer_two_control_reg <= `ISV_RST_BYTE;
            serial_one_control_reg <= `ISV_RST_BYTE;
            group_irq_flag_reg <= `ISV_RST_BYTE;
            group8_event_enable_reg <= `ISV_RST_BYTE;
            group8_event_flag_reg <= `ISV_RST_BYTE;
            group9_event_enable_reg <= `ISV_RST_BYTE;
            group9_event_flag_reg <= `ISV_RST_BYTE;
            group10_event_enable_reg <= `ISV_RST_BYTE;
            group10_event_flag_reg <= `ISV_RST_BYTE;
            enh_enable_reg <= `ISV_RST_BYTE;
            tier_reg <= `ISV_RST_TIER;
        end else begin
            if (wr_reg && addr_reg == `ISV_OFS_BASE_EN) begin
                base_irq_enable_reg <= hwdata[7:0] & 8'hef;
            end
            if (wr_reg && addr_reg == `ISV_OFS_GROUP_EN) begin
                group_irq_enable_reg <= hwdata[7:0] & 8'h07;
            end
            if (wr_reg && addr_reg == `ISV_OFS_G8_EN) begin
                group8_event_enable_reg <= hwdata[7:0] & `ISV_G8_MASK;
            end
            if (wr_reg && addr_reg == `ISV_OFS_G9_EN) begin
                group9_event_enable_reg <= hwdata[7:0] & `ISV_G9_MASK;
            end
            if (wr_reg && addr_reg == `ISV_OFS_G10_EN) begin
                group10_event_enable_reg <= hwdata[7:0] & `ISV_G10_MASK;
            end
            if (wr_reg && addr_reg == `ISV_OFS_ENH_EN) begin
                enh_enable_reg <= hwdata[7:0] & 8'h03;
            end
            if (wr_reg && addr_reg == `ISV_OFS_TIER) begin
                tier_reg <= hwdata[NSRC-1:0];
            end
            timer_control_reg <= flag_upd(timer_control_reg,
                wr_reg && addr_reg == `ISV_OFS_TMR_CTRL, hwdata[7:0] & 8'haf,
                {timer_one_ovf, 1'b0, timer_zero_ovf, 1'b0, set_ie1, 1'b0, set_ie0,
                1'b0});
            timer_two_control_reg <= flag_upd(timer_two_control_reg,
                wr_reg && addr_reg == `ISV_OFS_TMR2_CTRL, hwdata[7:0] & 8'hc0,
                {timer_two_ovf, timer_two_ext, 6'h00});
            serial_one_control_reg <= flag_upd(serial_one_control_reg,
                wr_reg && addr_reg == `ISV_OFS_SER1_CTRL, hwdata[7:0] & 8'h03,
                {6'h00, serial_one_tx, serial_one_rx});
            group8_event_flag_reg <= flag_upd(group8_event_flag_reg,
                wr_reg && addr_reg == `ISV_OFS_G8_FLAG, hwdata[7:0] & `ISV_G8_MASK,
                g8_ev);
            group9_event_flag_reg <= flag_upd(group9_event_flag_reg,
                wr_reg && addr_reg == `ISV_OFS_G9_FLAG, hwdata[7:0] & `ISV_G9_MASK,
                g9_ev);
            group10_event_flag_reg <= flag_upd(group10_event_flag_reg,
                wr_reg && addr_reg == `ISV_OFS_G10_FLAG, hwdata[7:0] & `ISV_G10_MASK,
                g10_ev);
            // group flag set by any enabled event; clearing it before the
            // event flag lets a leftover event flag stay silent
            group_irq_flag_reg <= flag_upd(group_irq_flag_reg,
                wr_reg && addr_reg == `ISV_OFS_GROUP_FLAG, hwdata[7:0] & 8'h70,
                {1'b0, |(g10_ev & group10_event_enable_reg),
                |(g9_ev & group9_event_enable_reg),
                |(g8_ev & group8_event_enable_reg), 4'h0});
        end
    end

    // vector outputs registered so the core sees a stable pick
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_request <= 1'b0;
            irq_tier <= 1'b0;
            irq_vector <= 8'h00;
            irq_number <= 4'h0;
        end else begin
            irq_request <= |pend;
            irq_tier <= |pend_hi;
            irq_vector <= (|pend) ? vector_of(pick_idx) : 8'h00;
            irq_number <= (|pend) ? number_of(pick_idx) : 4'h0;
        end
    end
endmodule // isv_irq_vectoring
`default_nettype wire

// file: dv/isv_core_model.sv
// processor core model that fetches the offered vector each cycle
`timescale 1ns/1ps
`default_nettype none
module isv_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_request,
    input wire logic irq_tier,
    input wire logic [7:0] irq_vector,
    input wire logic [3:0] irq_number,
    output var logic [12:0] fetch
);
    // a core ignores the vector lines while no request stands
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) fetch <= 13'h0000;
        else fetch <= irq_request ? {irq_tier, irq_number, irq_vector} : 13'h0000;
    end
endmodule // isv_core_model
`default_nettype wire

// file: dv/isv_irq_checker.sv
// concurrent checks on bus answers and vector outputs
`timescale 1ns/1ps
`default_nettype none
module isv_irq_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq_request,
    input wire logic irq_tier,
    input wire logic [7:0] irq_vector,
    input wire logic [3:0] irq_number
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [3:0] wr_hist;
    wire logic wr_t = hsel && htrans[1] && hready && hwrite;
    wire logic rd_t = hsel && htrans[1] && hready && !hwrite;
    // flags clear only by software, so a drop needs a recent write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_hist <= 4'h0;
        else wr_hist <= {wr_hist[2:0], wr_t};
    end
    sequence rd_taken; rd_t; endsequence
    sequence wr_taken; wr_t; endsequence
    sequence one_wait; !hreadyout ##1 hreadyout; endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_read_wait: assert property (rd_taken |=> one_wait)
        else $error("read wait state wrong");
    a_write_nowait: assert property (wr_taken |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property (!$past(rd_t) |=> $stable(hrdata))
        else $error("read data moved");
    a_vec_number: assert property (irq_request |-> irq_vector == 8'h03 + {1'b0, irq_number, 3'b000})
        else $error("vector and number disagree");
    a_idle_zero: assert property (!irq_request |-> irq_vector == 8'h00 && irq_number == 4'h0 && !irq_tier)
        else $error("vector shown without request");
    a_number_legal: assert property (irq_request |-> irq_number inside {0, 1, 2, 3, 5, 7, 8, 9, 10})
        else $error("reserved number offered");
    a_drop_cause: assert property ($fell(irq_request) |-> wr_hist != 4'h0)
        else $error("request dropped without write");
    c_read: cover property (rd_taken);
endmodule // isv_irq_checker
bind isv_irq_vectoring isv_irq_checker isv_irq_checker_inst (.*);
`default_nettype wire

// file: dv/isv_irq_vectoring_tb_top.sv
// self-checking bench for the interrupt vectoring block
`timescale 1ns/1ps
`default_nettype none
`include "isv_defines.vh"
module isv_irq_vectoring_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [24:0] ev = 25'h0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq_request;
    wire logic irq_tier;
    wire logic [7:0] irq_vector;
    wire logic [3:0] irq_number;
    wire logic [12:0] fetch;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h6483;
    logic [31:0] rd;
    logic [31:0] ex;
    logic [24:0] m;
    logic [8:0] t;
    localparam int EVB [25] = '{1, 5, 3, 7, 7, 6, 0, 1, 0, 1, 2, 3, 4, 5, 7, 2, 3, 5, 6, 7, 0, 1, 1, 1, 2};
    localparam logic [7:0] ENO [6] = '{8'h00, 8'h04, 8'h18, 8'h20, 8'h28, 8'h38};
    localparam logic [31:0] ENV [6] = '{32'hef, 32'h07, 32'hbf, 32'hec, 32'h07, 32'h03};
    localparam logic [7:0] CLR [7] = '{8'h1c, 8'h24, 8'h2c, 8'h08, 8'h0c, 8'h10, 8'h14};
    isv_irq_vectoring #(.NSRC(9)) isv_irq_vectoring_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_input_zero(~ev[0]), .ext_input_one(~ev[2]), .ext_input_two(~ev[24]),
        .timer_zero_ovf(ev[1]), .timer_one_ovf(ev[3]), .timer_two_ovf(ev[4]),
        .timer_two_ext(ev[5]), .serial_one_rx(ev[6]), .serial_one_tx(ev[7]),
        .serial_two_tx(ev[8]), .serial_two_rx(ev[9]), .serial_four_tx(ev[10]),
        .serial_four_rx(ev[11]), .serial_two_baud_ovf(ev[12]), .serial_four_baud_ovf(ev[13]),
        .calibration_pulse_output_one(ev[14]), .serial_five_tx(ev[15]),
        .serial_five_rx(ev[16]), .serial_five_baud_ovf(ev[17]), .rtc_second_pulse(ev[18]),
        .calibration_pulse_output_two(ev[19]), .rtc_illegal_data(ev[20]),
        .enh_serial_rx_flag(ev[21]), .enh_serial_tx_flag(ev[22]),
        .enh_serial_overflow_flag(ev[23]), .irq_request(irq_request), .irq_tier(irq_tier),
        .irq_vector(irq_vector), .irq_number(irq_number)
    );
    isv_core_model isv_core_model_inst (
        .hclk(hclk), .hresetn(hresetn), .irq_request(irq_request), .irq_tier(irq_tier),
        .irq_vector(irq_vector), .irq_number(irq_number), .fetch(fetch)
    );
    initial begin
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int num_of(int i);
        return i < 4 ? i : i < 6 ? 5 : i < 8 ? 7 : i < 15 ? 8 : i < 20 ? 9 : 10;
    endfunction
    function automatic logic [7:0] flag_ofs(int i);
        return i < 4 ? 8'h08 : i < 6 ? 8'h0c : i < 8 ? 8'h10 : i < 15 ? 8'h1c : i < 20 ? 8'h24 : 8'h2c;
    endfunction
    // ranks skip the reserved numbers 4 and 6, so rank and number differ
    function automatic logic [31:0] exp_status(logic [24:0] mk, logic [8:0] tr);
        int best;
        int n;
        logic [8:0] pend;
        pend = 9'h000;
        best = -1;
        for (int i = 0; i < 25; i++) begin
            n = num_of(i);
            if (mk[i]) pend[n < 4 ? n : n == 5 ? 4 : n - 2] = 1'b1;
        end
        for (int r = 8; r >= 0; r--) if (pend[r] && !tr[r]) best = r;
        for (int r = 8; r >= 0; r--) if (pend[r] && tr[r]) best = r;
        if (best < 0) return 32'h0;
        n = best < 4 ? best : best == 4 ? 5 : best + 2;
        return {18'h0, 1'b1, tr[best], n[3:0], 8'h03 + {n[4:0], 3'b000}};
    endfunction
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_ready();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic fire(input logic [24:0] mk);
        @(posedge hclk);
        ev <= mk;
        @(posedge hclk);
        ev <= 25'h0;
        repeat (8) @(posedge hclk);
    endtask
    task automatic clear_flags();
        foreach (CLR[k]) ahb(1'b1, CLR[k], 32'h0);
    endtask
    task automatic final_report();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            ahb(1'b0, 8'(a * 4), 32'h0);
            check_word(rd, 32'h0, "reset or unmapped");
        end
        foreach (ENO[k]) begin
            ahb(1'b1, ENO[k], 32'hff);
            ahb(1'b0, ENO[k], 32'h0);
            check_word(rd, ENV[k], "enable readback");
        end
        for (int i = 0; i < 25; i++) begin
            m = 25'h1 << i;
            ex = exp_status(m, 9'h000);
            fire(m);
            ahb(1'b0, `ISV_OFS_STATUS, 32'h0);
            check_word(rd, ex, "single source");
            check_word({19'h0, fetch}, {19'h0, ex[12:0]}, "core fetch");
            ahb(1'b0, flag_ofs(i), 32'h0);
            check_word(rd, 32'h1 << EVB[i], "event flag");
            if (i > 7) begin
                ahb(1'b0, `ISV_OFS_GROUP_FLAG, 32'h0);
                check_word(rd, 32'h10 << (num_of(i) - 8), "group flag");
            end
            clear_flags();
        end
        // global enable off must hide a pending flag, not lose it
        ahb(1'b1, `ISV_OFS_BASE_EN, 32'h6f);
        fire(25'h2);
        ahb(1'b0, `ISV_OFS_STATUS, 32'h0);
        check_word(rd, 32'h0, "global off");
        ahb(1'b1, `ISV_OFS_BASE_EN, 32'hef);
        ahb(1'b0, `ISV_OFS_STATUS, 32'h0);
        check_word(rd, 32'h210b, "global on");
        clear_flags();
        ahb(1'b1, `ISV_OFS_G8_EN, 32'hbe);
        fire(25'h100);
        ahb(1'b0, `ISV_OFS_GROUP_FLAG, 32'h0);
        check_word(rd, 32'h0, "event masked");
        ahb(1'b1, `ISV_OFS_G8_EN, 32'hff);
        ahb(1'b1, `ISV_OFS_GROUP_EN, 32'h06);
        fire(25'h100);
        ahb(1'b0, `ISV_OFS_STATUS, 32'h0);
        check_word(rd, 32'h0, "group off");
        ahb(1'b1, `ISV_OFS_GROUP_EN, 32'h07);
        ahb(1'b0, `ISV_OFS_STATUS, 32'h0);
        check_word(rd, 32'h2843, "group on");
        clear_flags();
        // edge mode: a pin held low does not set its flag again after the clear, a new fall sets it
        ev <= 25'h5;
        ahb(1'b1, `ISV_OFS_TMR_CTRL, 32'h05);
        ahb(1'b1, `ISV_OFS_TMR_CTRL, 32'h05);
        ahb(1'b0, `ISV_OFS_TMR_CTRL, 32'h0);
        check_word(rd, 32'h05, "edge mode held low");
        ev <= 25'h0;
        fire(25'h5);
        ahb(1'b0, `ISV_OFS_TMR_CTRL, 32'h0);
        check_word(rd, 32'h0f, "edge mode fall");
        clear_flags();
        for (int k = 0; k < 14; k++) begin
            m = k < 2 ? 25'h1ffffff : 25'(xorshift() & xorshift());
            t = k == 0 ? 9'h000 : k == 1 ? 9'h100 : 9'(xorshift());
            ahb(1'b1, `ISV_OFS_TIER, {23'h0, t});
            fire(m);
            ahb(1'b0, `ISV_OFS_STATUS, 32'h0);
            check_word(rd, exp_status(m, t), "tiered choice");
            clear_flags();
        end
        final_report();
    end
endmodule // isv_irq_vectoring_tb_top
`default_nettype wire
